// file: src/polled_pin_event_unit.sv
// Contract
// R01: event drives outputs active, output direction
// R02: continuous mode, no event: outputs complemented
// R03: configuration alone never starts sampling
// R04: sample at each instruction boundary
// R05: each boundary samples and updates all
// R06: configuration kept until changed
// R07: all event outputs update together
// R08: latched mode changes outputs only once
// R09: writing mode ten selects latch, rearms
// R10: event updates latch bit of input pins; the code updates the latch bit of event output pins only
// R11: any seen poll state sets latch
// R12: event output stays output until reconfigured
// R13: slot number zero to seven, switched on event
// R14: unconfigured slot defaults to zero
// R15: outputs update before slot switch
// R16: event output command drives complement now
// R17: mode two polls with continuous outputs
// R18: mode one stops polling, keeps configuration
// R19: after switch mode three->one, four->two
// R20: reset leaves polling off, nothing configured
`timescale 1ns/10ps
module polled_pin_event_unit
    import event_unit_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata,
    input wire logic check_point,
    output logic slot_switch,
    output logic [2:0] slot_target,
    input wire logic [PIN_COUNT-1:0] pin_in,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [3:0] mode;
    logic [3:0] next_mode;
    logic [2:0] run_slot;
    logic armed;
    logic last_event;
    seq_t state;
    seq_t next_state;

    logic [PIN_COUNT-1:0] hit;
    logic [PIN_COUNT-1:0] latch_q;
    logic [PIN_COUNT-1:0] dir_q;
    logic [PIN_COUNT-1:0] evout_mask;
    logic [PIN_COUNT-1:0] act_levels;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    wire wr_mode = wr_en && (addr == ADDR_MODE);
    wire wr_watch = wr_en && (addr == ADDR_WATCH);
    wire wr_evout = wr_en && (addr == ADDR_EVOUT);
    wire wr_slot = wr_en && (addr == ADDR_SLOT);
    wire wr_latch = wr_en && (addr == ADDR_LATCH);
    wire wr_release = wr_en && (addr == ADDR_RELEASE);
    wire cfg_any = wr_watch || wr_evout || wr_release || wr_latch;

    wire [3:0] cmd_pin = wdata[FLD_PIN_LSB +: 4];
    wire cmd_level = wdata[FLD_LEVEL_BIT];
    wire [3:0] wr_mode_val = wdata[3:0];
    wire [PIN_COUNT-1:0] latch_mask = wdata[FLD_MASK_LSB +: PIN_COUNT];
    wire [PIN_COUNT-1:0] latch_bits = wdata[PIN_COUNT-1:0];

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    wire mode_cont = (mode == MODE_CONT) || (mode == MODE_RUN_CONT); // R17
    wire mode_latch = (mode == MODE_LATCH);
    wire run_on = (mode == MODE_RUN) || (mode == MODE_RUN_CONT);
    wire polling = mode_cont || mode_latch || run_on; // R03 R18

    // ----------------------------------------
    // boundary sampling
    // ----------------------------------------
    wire any_hit = |hit;
    wire check = check_point && polling && (state == ST_IDLE); // R04
    wire event_now = check && any_hit;
    wire update_cont = check && mode_cont; // R05
    wire update_latch = event_now && mode_latch && armed; // R08 R11
    wire run_take = event_now && run_on; // R13

    // ----------------------------------------
    // pin cells
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin
            pin_event_cell u_cell (
                .clk_sys(clk_sys),
                .reset(reset),
                .pin_in(pin_in[gi]),
                .sel(cmd_pin == 4'(gi)),
                .watch_wr(wr_watch),
                .evout_wr(wr_evout),
                .release_wr(wr_release),
                .cmd_level(cmd_level),
                .latch_wr(wr_latch && latch_mask[gi]),
                .latch_data(latch_bits[gi]),
                .update_cont(update_cont), // R07
                .update_latch(update_latch), // R07
                .event_now(event_now),
                .watch_hit(hit[gi]),
                .out_latch(latch_q[gi]),
                .drive_dir(dir_q[gi]),
                .is_evout(evout_mask[gi]),
                .act_level(act_levels[gi])
            );
        end
    endgenerate

    assign pin_out = latch_q;
    assign pin_oe = dir_q;

    // ----------------------------------------
    // mode and slot registers
    // ----------------------------------------
    always_comb begin
        next_mode = mode;
        if (wr_mode) begin
            next_mode = wr_mode_val;
        end else if (run_take) begin
            next_mode = (mode == MODE_RUN) ? MODE_HOLD : MODE_CONT; // R19
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode <= RST_MODE; // R20
            run_slot <= RST_SLOT; // R14 R20
        end else begin
            mode <= next_mode; // R06
            if (wr_slot) begin
                run_slot <= wdata[2:0]; // R13
            end
        end
    end

    // ----------------------------------------
    // latch arming
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            armed <= 1'b0;
            last_event <= 1'b0;
        end else begin
            if (wr_mode && (wr_mode_val == MODE_LATCH)) begin
                armed <= 1'b1; // R09
            end else if (update_latch) begin
                armed <= 1'b0; // R08
            end
            if (check) begin
                last_event <= any_hit;
            end
        end
    end

    // ----------------------------------------
    // slot switch sequence
    // ----------------------------------------
    always_comb begin
        case (state)
            ST_IDLE: next_state = run_take ? ST_SWITCH : ST_IDLE;
            ST_SWITCH: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= ST_IDLE;
            slot_switch <= 1'b0;
            slot_target <= RST_SLOT;
        end else begin
            state <= next_state;
            slot_switch <= (state == ST_SWITCH); // R15
            if (run_take) begin
                slot_target <= run_slot; // R13
            end
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    wire [DATA_W-1:0] rd_status = {latch_q, 13'h0, polling, last_event, armed};
    wire [DATA_W-1:0] rd_mux =
        (addr == ADDR_MODE) ? {28'h0000000, mode} :
        (addr == ADDR_SLOT) ? {29'h0, run_slot} :
        (addr == ADDR_LATCH) ? {16'h0000, latch_q} : // R10
        (addr == ADDR_DIR) ? {16'h0000, dir_q} :
        (addr == ADDR_STATUS) ? rd_status :
        32'h00000000;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= rd_en ? rd_mux : 32'h00000000;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_run_event;
        run_take && !wr_mode;
    endsequence

    sequence s_switch_after_update;
        !slot_switch ##1 slot_switch;
    endsequence

    property p_switch_order;
        s_run_event |=> s_switch_after_update;
    endproperty

    sequence s_latch_arm;
        wr_mode && (wr_mode_val == MODE_LATCH);
    endsequence

    sequence s_latch_hit;
        update_latch && !cfg_any;
    endsequence

    AST_CONT_ACTIVE: assert property (update_cont && event_now && !cfg_any // R01
        |=> ((pin_out ^ act_levels) & evout_mask) == 16'h0000)
        else $error("event outputs not at active level");

    AST_CONT_IDLE: assert property (update_cont && !any_hit && !cfg_any // R02
        |=> ((pin_out ^ ~act_levels) & evout_mask) == 16'h0000)
        else $error("event outputs not complemented");

    AST_NO_POLL: assert property (!polling && !cfg_any // R03
        |=> $stable(pin_out) && $stable(pin_oe))
        else $error("pins changed while polling off");

    AST_SLOT_ORDER: assert property (p_switch_order) // R15
        else $error("slot switch not after output update");

    AST_SLOT_VALUE: assert property (s_run_event |-> ##2 slot_target == $past(run_slot, 2)) // R13
        else $error("wrong slot target");

    AST_ONE_SHOT: assert property (s_run_event // R19
        |=> mode == (($past(mode) == MODE_RUN) ? MODE_HOLD : MODE_CONT))
        else $error("run mode not demoted after switch");

    AST_ARM: assert property (s_latch_arm |=> armed && mode == MODE_LATCH) // R09
        else $error("latch mode write did not arm");

    AST_LATCH_ONCE: assert property (mode_latch && !armed && !cfg_any && !wr_mode // R08
        |=> $stable(pin_out))
        else $error("latched outputs changed twice");

    AST_LATCH_SET: assert property (s_latch_hit // R11
        |=> ((pin_out ^ act_levels) & evout_mask) == 16'h0000
        && armed == $past(wr_mode && (wr_mode_val == MODE_LATCH)))
        else $error("latch not set on seen poll state");

    AST_EVOUT_CFG: assert property (wr_evout // R16
        |=> pin_oe[$past(cmd_pin)] && (pin_out[$past(cmd_pin)] != $past(cmd_level)))
        else $error("event output not driven to complement");

    AST_DIR_HOLD: assert property (!cfg_any && !event_now |=> $stable(pin_oe)) // R12
        else $error("direction changed without command");

    AST_RETAIN: assert property (!wr_mode && !run_take && !wr_slot // R06
        |=> $stable(mode) && $stable(run_slot))
        else $error("configuration lost");

    // ----------------------------------------
    // checks on commands, reset and reads
    // ----------------------------------------
    AST_RESET_CLEAR: assert property ($fell(reset) // R20
        |-> mode == RST_MODE && run_slot == RST_SLOT && !armed && evout_mask == 16'h0000
        && pin_out == 16'h0000 && pin_oe == 16'h0000 && !slot_switch)
        else $error("state not cleared by reset");

    AST_SWITCH_PULSE: assert property (slot_switch |=> !slot_switch) // R19
        else $error("slot switch longer than one cycle");

    AST_NO_REPEAT: assert property (state == ST_SWITCH // R19
        |-> !update_cont && !update_latch && !run_take)
        else $error("sample taken during slot switch");

    AST_CFG_KEEP: assert property (!cfg_any // R06
        |=> $stable(evout_mask) && $stable(act_levels))
        else $error("pin configuration changed without command");

    AST_HOLD_QUIET: assert property (mode == MODE_HOLD // R18
        |-> !update_cont && !update_latch && !run_take)
        else $error("polling active in hold mode");

    AST_RUN_NO_OUT: assert property (mode == MODE_RUN && !cfg_any |=> $stable(pin_out)) // R17
        else $error("outputs updated in run only mode");

    AST_WATCH_CFG: assert property (wr_watch |=> !pin_oe[$past(cmd_pin)]) // R12
        else $error("watched pin still driven");

    AST_RELEASE: assert property (wr_release // R12
        |=> !pin_oe[$past(cmd_pin)] && !evout_mask[$past(cmd_pin)])
        else $error("released pin still an event output");

    AST_LATCH_WRITE: assert property (wr_latch // R08
        |=> ((pin_out ^ $past(latch_bits)) & $past(latch_mask)) == 16'h0000)
        else $error("software latch write lost");

    AST_TARGET_HOLD: assert property (!run_take |=> $stable(slot_target)) // R13
        else $error("slot target changed without event");

    AST_LATCH_READ: assert property (rd_en && addr == ADDR_LATCH // R10
        |=> rdata == {16'h0000, $past(pin_out)})
        else $error("latch read does not show pin latches");

    AST_DIR_READ: assert property (rd_en && addr == ADDR_DIR // R12
        |=> rdata == {16'h0000, $past(pin_oe)})
        else $error("direction read does not show enables");

    AST_STATUS_POLL: assert property (rd_en && addr == ADDR_STATUS // R03
        |=> rdata[FLD_STAT_POLL] == $past(polling))
        else $error("status does not show polling");

    AST_STATUS_ARMED: assert property (rd_en && addr == ADDR_STATUS // R09
        |=> rdata[FLD_STAT_ARMED] == $past(armed) && rdata[FLD_STAT_PINS_LSB +: PIN_COUNT] == $past(pin_out))
        else $error("status does not show arming");

    AST_EVENT_SEEN: assert property (check |=> last_event == $past(any_hit)) // R04
        else $error("sample result not recorded");

    AST_MODE_WRITE: assert property (wr_mode |=> mode == $past(wr_mode_val)) // R06
        else $error("mode write lost");

    AST_SLOT_WRITE: assert property (wr_slot |=> run_slot == $past(wdata[2:0])) // R13
        else $error("slot write lost");

endmodule

// file: src/event_unit_pkg.sv
package event_unit_pkg;

    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int PIN_COUNT = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_WATCH = 8'h04;
    localparam logic [7:0] ADDR_EVOUT = 8'h08;
    localparam logic [7:0] ADDR_SLOT = 8'h0c;
    localparam logic [7:0] ADDR_LATCH = 8'h10;
    localparam logic [7:0] ADDR_DIR = 8'h14;
    localparam logic [7:0] ADDR_RELEASE = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int FLD_PIN_LSB = 0;
    localparam int FLD_LEVEL_BIT = 4;
    localparam int FLD_MASK_LSB = 16;
    localparam int FLD_STAT_ARMED = 0;
    localparam int FLD_STAT_EVENT = 1;
    localparam int FLD_STAT_POLL = 2;
    localparam int FLD_STAT_PINS_LSB = 16;

    // ----------------------------------------
    // watch mode encodings
    // ----------------------------------------
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_HOLD = 4'h1;
    localparam logic [3:0] MODE_CONT = 4'h2;
    localparam logic [3:0] MODE_RUN = 4'h3;
    localparam logic [3:0] MODE_RUN_CONT = 4'h4;
    localparam logic [3:0] MODE_LATCH = 4'ha;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [3:0] RST_MODE = MODE_OFF;
    localparam logic [2:0] RST_SLOT = 3'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SWITCH = 2'b10
    } seq_t;

endpackage

// file: src/pin_event_cell.sv
`timescale 1ns/10ps
module pin_event_cell
    import event_unit_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic pin_in,
    input wire logic sel,
    input wire logic watch_wr,
    input wire logic evout_wr,
    input wire logic release_wr,
    input wire logic cmd_level,
    input wire logic latch_wr,
    input wire logic latch_data,
    input wire logic update_cont,
    input wire logic update_latch,
    input wire logic event_now,
    output logic watch_hit,
    output logic out_latch,
    output logic drive_dir,
    output logic is_evout,
    output logic act_level
);

    logic is_watch;
    logic watch_level;

    assign watch_hit = is_watch && (pin_in == watch_level);

    // ----------------------------------------
    // per pin configuration and output latch
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            is_watch <= 1'b0;
            watch_level <= 1'b0;
            is_evout <= 1'b0;
            act_level <= 1'b0;
            out_latch <= 1'b0;
            drive_dir <= 1'b0;
        end else if (sel && evout_wr) begin
            is_evout <= 1'b1;
            is_watch <= 1'b0;
            act_level <= cmd_level;
            out_latch <= ~cmd_level; // R16
            drive_dir <= 1'b1; // R16
        end else if (sel && watch_wr) begin
            is_watch <= 1'b1;
            watch_level <= cmd_level;
            drive_dir <= 1'b0; // R12
        end else if (sel && release_wr) begin
            is_watch <= 1'b0;
            is_evout <= 1'b0;
            drive_dir <= 1'b0; // R12
        end else if (latch_wr) begin
            out_latch <= latch_data;
        end else if (is_evout && update_cont) begin
            out_latch <= event_now ? act_level : ~act_level; // R02
            if (event_now) begin
                drive_dir <= drive_dir | ~is_watch; // R01
            end
        end else if (is_evout && update_latch) begin
            out_latch <= act_level; // R10
            drive_dir <= drive_dir | ~is_watch; // R01
        end
    end

endmodule

// file: sim/pin_partner.sv
`timescale 1ns/10ps
// ----------------------------------------
// external circuitry on the pins
// ----------------------------------------
module pin_partner
    import event_unit_pkg::*;
(
    input wire logic [PIN_COUNT-1:0] pin_out,
    input wire logic [PIN_COUNT-1:0] pin_oe,
    input wire logic [PIN_COUNT-1:0] ext_level,
    output logic [PIN_COUNT-1:0] pin_in
);
    // driven pins read back their own level, others follow the outside source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// file: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import event_unit_pkg::*;
    logic clk_sys;
    logic reset;
    logic wr_en;
    logic rd_en;
    logic check_point;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic slot_switch;
    logic [2:0] slot_target;
    logic [PIN_COUNT-1:0] pin_in;
    logic [PIN_COUNT-1:0] pin_out;
    logic [PIN_COUNT-1:0] pin_oe;
    logic [PIN_COUNT-1:0] ext_level;
    int miscompares;
    int checks;
    logic [15:0] row_in[5] = '{16'h0001, 16'h0000, 16'h0001, 16'h0001, 16'h0000};
    logic [31:0] row_exp[5] = '{32'h000c, 32'h0002, 32'h000c, 32'h000c, 32'h0002};
    logic [7:0] rst_addr[6] = '{ADDR_MODE, ADDR_SLOT, ADDR_LATCH, ADDR_DIR, ADDR_STATUS, 8'h20};

    polled_pin_event_unit i_polled_pin_event_unit (.clk_sys(clk_sys), .reset(reset), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .check_point(check_point),
        .slot_switch(slot_switch), .slot_target(slot_target), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));
    pin_partner i_pin_partner (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        cmp(rdata, exp);
    endtask
    task automatic cp(input logic [15:0] lvl);
        @(posedge clk_sys);
        ext_level <= lvl;
        check_point <= 1'b1;
        @(posedge clk_sys);
        check_point <= 1'b0;
        #1;
    endtask
    task automatic run_ev(input logic [2:0] want_out, input logic [2:0] slot);
        cp(16'h0001);
        cmp({29'h0, pin_out[3:1]}, {29'h0, want_out});
        cmp({31'h0, slot_switch}, 32'h0);
        @(posedge clk_sys);
        #1;
        cmp({28'h0, slot_switch, slot_target}, {28'h0, 1'b1, slot});
        @(posedge clk_sys);
        #1;
        cmp({31'h0, slot_switch}, 32'h0);
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        check_point = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        ext_level = 16'h0000;
        miscompares = 0;
        checks = 0;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(rst_addr[i], 32'h0);
        end
        $display("test reset done");
        wr(ADDR_WATCH, 32'h10);
        wr(ADDR_EVOUT, 32'h01);
        wr(ADDR_EVOUT, 32'h12);
        wr(ADDR_EVOUT, 32'h13);
        rd(ADDR_LATCH, 32'h0002);
        cp(16'h0001);
        rd(ADDR_LATCH, 32'h0002);
        rd(ADDR_DIR, 32'h000e);
        wr(ADDR_MODE, 32'h2);
        for (int i = 0; i < 5; i++) begin
            cp(row_in[i]);
            cmp({16'h0, pin_out}, row_exp[i]);
        end
        $display("test continuous done");
        wr(ADDR_MODE, 32'h1);
        cp(16'h0001);
        rd(ADDR_LATCH, 32'h0002);
        wr(ADDR_MODE, 32'h2);
        cp(16'h0001);
        rd(ADDR_LATCH, 32'h000c);
        cp(16'h0000);
        $display("test hold done");
        wr(ADDR_EVOUT, 32'h14);
        rd(ADDR_DIR, 32'h001e);
        wr(ADDR_WATCH, 32'h14);
        rd(ADDR_DIR, 32'h000e);
        wr(ADDR_MODE, {28'h0, MODE_LATCH});
        cp(16'h0000);
        rd(ADDR_LATCH, 32'h0002);
        cp(16'h0010);
        cp(16'h0000);
        rd(ADDR_LATCH, 32'h001c);
        rd(ADDR_DIR, 32'h000e);
        wr(ADDR_LATCH, 32'h00100000);
        cp(16'h0010);
        rd(ADDR_LATCH, 32'h000c);
        wr(ADDR_MODE, {28'h0, MODE_LATCH});
        cp(16'h0010);
        rd(ADDR_LATCH, 32'h001c);
        $display("test latched done");
        wr(ADDR_RELEASE, 32'h4);
        cp(16'h0000);
        wr(ADDR_MODE, 32'h4);
        run_ev(3'b110, 3'h0);
        rd(ADDR_MODE, 32'h2);
        cp(16'h0000);
        cmp({29'h0, pin_out[3:1]}, 32'h1);
        wr(ADDR_SLOT, 32'h7);
        wr(ADDR_MODE, 32'h3);
        run_ev(3'b001, 3'h7);
        rd(ADDR_MODE, 32'h1);
        rd(ADDR_SLOT, 32'h7);
        $display("test slot switch done");
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        cmp({pin_oe, pin_out}, 32'h0);
        cmp({28'h0, slot_switch, slot_target}, 32'h0);
        rd(ADDR_SLOT, 32'h0);
        rd(ADDR_MODE, 32'h0);
        rd(ADDR_DIR, 32'h0);
        $display("test midrun reset done");
        complete_run();
    end
endmodule
